// File: hw/ctmcp_pkg.sv
// Shared constants and types of the counter/timer command block
package ctmcp_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int NUM_CHAN = 5;
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;

  // ---------------------------------------------------------------
  // Port select
  // ---------------------------------------------------------------
  localparam logic PORT_DATA = 1'b0;
  localparam logic PORT_CMD = 1'b1;

  // ---------------------------------------------------------------
  // Command upper-bit codes
  // ---------------------------------------------------------------
  localparam logic [2:0] OP_PTR = 3'h0;
  localparam logic [2:0] OP_ARM = 3'h1;
  localparam logic [2:0] OP_LOAD = 3'h2;
  localparam logic [2:0] OP_LDARM = 3'h3;
  localparam logic [2:0] OP_DISSAVE = 3'h4;
  localparam logic [2:0] OP_SAVE = 3'h5;
  localparam logic [2:0] OP_DISARM = 3'h6;
  localparam logic [2:0] OP_MISC = 3'h7;

  // Sub-codes of the 111 group, bits 4:3
  localparam logic [1:0] SUB_CLR = 2'h0;
  localparam logic [1:0] SUB_SET = 2'h1;
  localparam logic [1:0] SUB_STEP = 2'h2;

  // Low bits of master control functions
  localparam logic [2:0] MC_SEQ = 3'h0;
  localparam logic [2:0] MC_GATE = 3'h6;
  localparam logic [2:0] MC_WIDTH = 3'h7;
  localparam logic [7:0] CMD_MASTER_RESET = 8'hFF;

  // ---------------------------------------------------------------
  // Pointer fields
  // ---------------------------------------------------------------
  localparam logic [2:0] GRP_FIRST = 3'h1;
  localparam logic [2:0] GRP_LAST = 3'h5;
  localparam logic [2:0] GRP_CTRL = 3'h7;
  localparam logic [1:0] EL_MODE = 2'h0;
  localparam logic [1:0] EL_LOADR = 2'h1;
  localparam logic [1:0] EL_HOLD = 2'h2;
  localparam logic [1:0] EL_HOLDINC = 2'h3;
  localparam logic [1:0] EL_ALARM1 = 2'h0;
  localparam logic [1:0] EL_ALARM2 = 2'h1;
  localparam logic [1:0] EL_MASTER = 2'h2;
  localparam logic [1:0] EL_STATUS = 2'h3;

  // ---------------------------------------------------------------
  // Master mode bit positions and reset values
  // ---------------------------------------------------------------
  localparam int MM_OUTPUT_GATE = 12;
  localparam int MM_BUS_WIDTH = 13;
  localparam int MM_SEQ_DISABLE = 14;
  localparam logic [15:0] MM_RESET = 16'h0000;
  localparam logic [1:0] EL_RESET = 2'h0;
  localparam logic [2:0] GRP_RESET = 3'h1;
  localparam logic BYTE_PTR_RESET = 1'b1;

  // ---------------------------------------------------------------
  // Per-counter command bundle
  // ---------------------------------------------------------------
  typedef struct packed {
    logic clear;
    logic arm;
    logic disarm;
    logic load;
    logic save;
    logic step;
    logic set_out;
    logic clr_out;
  } ctmcp_chan_cmd_t;

  // Register write into one counter group
  typedef struct packed {
    logic en;
    logic [1:0] sel;
    logic [15:0] data;
  } ctmcp_chan_wr_t;

endpackage

// File: hw/ctmcp_chan.sv
// One 16-bit counter with mode, load and hold registers
`timescale 1ns/1ps
`default_nettype none
module ctmcp_chan (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_tick,
  input wire ctmcp_pkg::ctmcp_chan_cmd_t i_cmd,
  input wire ctmcp_pkg::ctmcp_chan_wr_t i_wr,
  output logic [15:0] o_mode,
  output logic [15:0] o_load,
  output logic [15:0] o_hold,
  output logic o_out,
  output logic o_armed
);
  import ctmcp_pkg::*;

  logic [15:0] mode_q, load_q, hold_q, count_q;
  logic [15:0] mode_d, load_d, hold_d, count_d;
  logic out_q, out_d, armed_q, armed_d;
  logic dec;
  logic wrap;

  // -------------------------------------------------------------
  // Counting
  // -------------------------------------------------------------
  assign dec = i_cmd.step | (armed_q & i_tick);
  assign wrap = (count_q == 16'h0000);

  always_comb begin
    mode_d = mode_q;
    load_d = load_q;
    hold_d = hold_q;
    count_d = count_q;
    out_d = out_q;
    armed_d = armed_q;
    if (i_cmd.clear) begin
      mode_d = 16'h0000;
      load_d = 16'h0000;
      hold_d = 16'h0000;
      count_d = 16'h0000;
      out_d = 1'b0;
      armed_d = 1'b0;
    end else begin
      if (i_wr.en && i_wr.sel == EL_MODE) mode_d = i_wr.data;
      if (i_wr.en && i_wr.sel == EL_LOADR) load_d = i_wr.data;
      if (i_wr.en && i_wr.sel[1]) hold_d = i_wr.data;
      if (i_cmd.save) hold_d = count_q;
      if (i_cmd.load) begin
        count_d = load_q;
      end else if (dec) begin
        count_d = wrap ? load_q : count_q - 16'h0001;
        if (wrap) out_d = ~out_q;
      end
      if (i_cmd.clr_out) out_d = 1'b0;
      if (i_cmd.set_out) out_d = 1'b1;
      if (i_cmd.arm) armed_d = 1'b1;
      if (i_cmd.disarm) armed_d = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      mode_q <= 16'h0000;
      load_q <= 16'h0000;
      hold_q <= 16'h0000;
      count_q <= 16'h0000;
      out_q <= 1'b0;
      armed_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      load_q <= load_d;
      hold_q <= hold_d;
      count_q <= count_d;
      out_q <= out_d;
      armed_q <= armed_d;
    end
  end

  assign o_mode = mode_q;
  assign o_load = load_q;
  assign o_hold = hold_q;
  assign o_out = out_q;
  assign o_armed = armed_q;
endmodule // ctmcp_chan
`default_nettype wire

// File: hw/ctmcp_top.sv
// Command decoder and pointer-based register access of the counter block
`timescale 1ns/1ps
`default_nettype none
module ctmcp_top #(
  parameter int NCH = ctmcp_pkg::NUM_CHAN
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_port_sel,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_wdata,
  input wire logic [NCH-1:0] i_count_src,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  output logic [NCH-1:0] o_counter_out,
  output logic o_output_gate_bit,
  output logic o_bus_width_bit,
  output logic o_sequencing_disable_bit
);
  import ctmcp_pkg::*;

  // -------------------------------------------------------------
  // Port strobes
  // -------------------------------------------------------------
  logic cmd_wr, cmd_rd, data_wr, data_rd, xfer;
  assign cmd_wr = i_wr & (i_port_sel == PORT_CMD);
  assign cmd_rd = i_rd & (i_port_sel == PORT_CMD);
  assign data_wr = i_wr & (i_port_sel == PORT_DATA);
  assign data_rd = i_rd & (i_port_sel == PORT_DATA);
  assign xfer = data_wr | data_rd;

  // -------------------------------------------------------------
  // State
  // -------------------------------------------------------------
  logic [15:0] mm_q, mm_d;
  logic [15:0] alarm1_q, alarm1_d;
  logic [15:0] alarm2_q, alarm2_d;
  logic [1:0] elem_q, elem_d;
  logic [2:0] grp_q, grp_d;
  logic byte_q, byte_d;
  logic [7:0] lat_q, lat_d;
  logic [7:0] rdata_q, rdata_d;
  logic rvalid_q;

  // -------------------------------------------------------------
  // Command fields
  // -------------------------------------------------------------
  logic [2:0] op;
  logic [4:0] mask;
  logic [1:0] sub;
  logic [2:0] num;
  logic num_ok;
  logic [2:0] num_idx;
  logic is_misc, master_rst;
  logic ptr_load;
  assign op = i_wdata[7:5];
  assign mask = i_wdata[4:0];
  assign sub = i_wdata[4:3];
  assign num = i_wdata[2:0];
  assign num_ok = (num >= GRP_FIRST) && (num <= GRP_LAST);
  assign num_idx = num - 3'h1;
  assign is_misc = cmd_wr && (op == OP_MISC);
  assign master_rst = cmd_wr && (i_wdata == CMD_MASTER_RESET);
  assign ptr_load = cmd_wr && (op == OP_PTR);

  // Mask command kinds
  logic do_arm, do_load, do_save, do_disarm;
  assign do_arm = cmd_wr && (op == OP_ARM || op == OP_LDARM);
  assign do_load = cmd_wr && (op == OP_LOAD || op == OP_LDARM);
  assign do_save = cmd_wr && (op == OP_DISSAVE || op == OP_SAVE);
  assign do_disarm = cmd_wr && (op == OP_DISSAVE || op == OP_DISARM);

  // Single-counter kinds
  logic one_clr, one_set, one_step;
  assign one_clr = is_misc && sub == SUB_CLR && num_ok;
  assign one_set = is_misc && sub == SUB_SET && num_ok;
  assign one_step = is_misc && sub == SUB_STEP && num_ok;

  // Master control codes
  logic mc_lo, mc_hi;
  logic seq_clr, seq_set, gate_clr, gate_set, width_clr, width_set;
  assign mc_lo = is_misc && sub == SUB_CLR;
  assign mc_hi = is_misc && sub == SUB_SET;
  assign seq_clr = mc_lo && (num == MC_SEQ);
  assign seq_set = mc_hi && (num == MC_SEQ);
  assign gate_clr = mc_lo && (num == MC_GATE);
  assign gate_set = mc_hi && (num == MC_GATE);
  assign width_clr = mc_lo && (num == MC_WIDTH);
  assign width_set = mc_hi && (num == MC_WIDTH);

  // -------------------------------------------------------------
  // Pointer decode
  // -------------------------------------------------------------
  logic grp_ctl, grp_cnt;
  logic [2:0] cidx;
  assign grp_ctl = (grp_q == GRP_CTRL);
  assign grp_cnt = (grp_q >= GRP_FIRST) && (grp_q <= GRP_LAST);
  assign cidx = grp_q - 3'h1;

  logic bus16, seq_off;
  assign bus16 = mm_q[MM_BUS_WIDTH];
  assign seq_off = mm_q[MM_SEQ_DISABLE];

  // Transfer ends on the high byte, or on every access in word mode
  logic done;
  assign done = xfer & (bus16 | ~byte_q);

  logic [15:0] wr_word;
  assign wr_word = bus16 ? {8'h00, i_wdata} : {i_wdata, lat_q};
  logic wr_commit;
  assign wr_commit = data_wr & done;

  // -------------------------------------------------------------
  // Count source synchroniser
  // -------------------------------------------------------------
  // Two stages against metastability, the third only for edge detection
  logic [NCH-1:0] src_s1_q, src_s2_q, src_s3_q;
  logic [NCH-1:0] src_rise;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      src_s1_q <= '0;
      src_s2_q <= '0;
      src_s3_q <= '0;
    end else begin
      src_s1_q <= i_count_src;
      src_s2_q <= src_s1_q;
      src_s3_q <= src_s2_q;
    end
  end

  assign src_rise = src_s2_q & ~src_s3_q;

  // -------------------------------------------------------------
  // Counter channels
  // -------------------------------------------------------------
  logic [15:0] ch_mode [NCH];
  logic [15:0] ch_load [NCH];
  logic [15:0] ch_hold [NCH];
  logic [NCH-1:0] ch_out;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_chan
      ctmcp_chan_cmd_t cmd;
      ctmcp_chan_wr_t wr;
      logic hit;
      logic sel;
      assign hit = (num_idx == 3'(g));
      assign sel = mask[g];
      assign cmd.clear = master_rst;
      assign cmd.arm = do_arm & sel;
      assign cmd.load = do_load & sel;
      assign cmd.save = do_save & sel;
      assign cmd.disarm = do_disarm & sel;
      assign cmd.step = one_step & hit;
      assign cmd.set_out = one_set & hit;
      assign cmd.clr_out = one_clr & hit;
      assign wr.en = wr_commit & grp_cnt & (cidx == 3'(g));
      assign wr.sel = elem_q;
      assign wr.data = wr_word;
      ctmcp_chan u_chan (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_tick(src_rise[g]),
        .i_cmd(cmd),
        .i_wr(wr),
        .o_mode(ch_mode[g]),
        .o_load(ch_load[g]),
        .o_hold(ch_hold[g]),
        .o_out(ch_out[g]),
        .o_armed()
      );
    end
  endgenerate

  // -------------------------------------------------------------
  // Read selection
  // -------------------------------------------------------------
  logic [15:0] cnt_word, ctl_word, rd_word;
  logic [7:0] status;
  logic [2:0] cidx_c;
  assign cidx_c = grp_cnt ? cidx : 3'h0;
  assign cnt_word = (elem_q == EL_MODE) ? ch_mode[cidx_c] :
                    (elem_q == EL_LOADR) ? ch_load[cidx_c] :
                    ch_hold[cidx_c];
  assign ctl_word = (elem_q == EL_ALARM1) ? alarm1_q :
                    (elem_q == EL_ALARM2) ? alarm2_q :
                    (elem_q == EL_MASTER) ? mm_q :
                    {8'h00, status};
  assign rd_word = grp_ctl ? ctl_word : (grp_cnt ? cnt_word : 16'h0000);
  // Only the byte pointer of the pointer state is visible
  assign status = {2'b00, ch_out[4:0], byte_q};

  // Word mode always hands over the low byte
  logic rd_low;
  assign rd_low = byte_q | bus16;

  always_comb begin
    rdata_d = rdata_q;
    if (cmd_rd) begin
      rdata_d = status;
    end else if (data_rd) begin
      rdata_d = rd_low ? rd_word[7:0] : rd_word[15:8];
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= i_rd;
    end
  end

  // -------------------------------------------------------------
  // Control-group register writes
  // -------------------------------------------------------------
  logic ctl_wr;
  logic wr_alarm1, wr_alarm2, wr_master;
  assign ctl_wr = wr_commit & grp_ctl;
  assign wr_alarm1 = ctl_wr && (elem_q == EL_ALARM1);
  assign wr_alarm2 = ctl_wr && (elem_q == EL_ALARM2);
  assign wr_master = ctl_wr && (elem_q == EL_MASTER);
  // Status element is read-only: a write to it falls through

  always_comb begin
    mm_d = mm_q;
    alarm1_d = alarm1_q;
    alarm2_d = alarm2_q;
    if (wr_alarm1) alarm1_d = wr_word;
    if (wr_alarm2) alarm2_d = wr_word;
    if (wr_master) mm_d = wr_word;
    if (seq_clr) mm_d[MM_SEQ_DISABLE] = 1'b0;
    if (seq_set) mm_d[MM_SEQ_DISABLE] = 1'b1;
    if (gate_clr) mm_d[MM_OUTPUT_GATE] = 1'b0;
    if (gate_set) mm_d[MM_OUTPUT_GATE] = 1'b1;
    if (width_clr) mm_d[MM_BUS_WIDTH] = 1'b0;
    if (width_set) mm_d[MM_BUS_WIDTH] = 1'b1;
    if (master_rst) begin
      mm_d = MM_RESET;
      alarm1_d = 16'h0000;
      alarm2_d = 16'h0000;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      mm_q <= MM_RESET;
      alarm1_q <= 16'h0000;
      alarm2_q <= 16'h0000;
    end else begin
      mm_q <= mm_d;
      alarm1_q <= alarm1_d;
      alarm2_q <= alarm2_d;
    end
  end

  // -------------------------------------------------------------
  // Pointer sequencing
  // -------------------------------------------------------------
  logic [1:0] elem_nx;
  logic [2:0] grp_nx;
  assign elem_nx = (elem_q == EL_HOLD) ? EL_MODE : elem_q + 2'h1;
  assign grp_nx = (grp_q == GRP_LAST) ? GRP_FIRST : grp_q + 3'h1;

  always_comb begin
    elem_d = elem_q;
    grp_d = grp_q;
    byte_d = byte_q;
    lat_d = lat_q;
    if (data_wr && byte_q) lat_d = i_wdata;
    if (xfer && !bus16) byte_d = ~byte_q;
    if (done && !seq_off) begin
      if (grp_cnt && elem_q == EL_HOLDINC) begin
        grp_d = grp_nx;
      end else if (elem_q != EL_HOLDINC && (grp_cnt || grp_ctl)) begin
        elem_d = elem_nx;
      end
    end
    if (ptr_load) begin
      elem_d = i_wdata[4:3];
      grp_d = i_wdata[2:0];
      byte_d = 1'b1;
    end
    if (master_rst) begin
      elem_d = EL_RESET;
      grp_d = GRP_RESET;
      byte_d = BYTE_PTR_RESET;
    end
  end

  // -------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      elem_q <= EL_RESET;
      grp_q <= GRP_RESET;
      byte_q <= BYTE_PTR_RESET;
      lat_q <= 8'h00;
    end else begin
      elem_q <= elem_d;
      grp_q <= grp_d;
      byte_q <= byte_d;
      lat_q <= lat_d;
    end
  end

  assign o_rdata = rdata_q;
  assign o_rvalid = rvalid_q;
  assign o_counter_out = ch_out;
  assign o_output_gate_bit = mm_q[MM_OUTPUT_GATE];
  assign o_bus_width_bit = mm_q[MM_BUS_WIDTH];
  assign o_sequencing_disable_bit = mm_q[MM_SEQ_DISABLE];
endmodule // ctmcp_top
`default_nettype wire

// File: testbench/ctmcp_props.sv
// Port-level assertions of the counter command block
`timescale 1ns/1ps
`default_nettype none
module ctmcp_props #(
  parameter int NCH = 5
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_port_sel,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_wdata,
  input wire logic o_rvalid,
  input wire logic [NCH-1:0] o_counter_out,
  input wire logic o_output_gate_bit,
  input wire logic o_bus_width_bit,
  input wire logic o_sequencing_disable_bit
);
  import ctmcp_pkg::*;
  // ---------------------------------------------------------------
  // Command decode helpers
  // ---------------------------------------------------------------
  wire logic cmd_wr;
  wire logic n_ok;
  wire logic [NCH-1:0] n_sel;
  assign cmd_wr = i_wr && (i_port_sel == PORT_CMD);
  assign n_ok = (i_wdata[2:0] != 3'h0) && (32'(i_wdata[2:0]) <= NCH);
  assign n_sel = NCH'(1) << (i_wdata[2:0] - 3'h1);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);
  chk_read_answer: assert property (i_rd |=> o_rvalid)
    else $error("read strobe not answered next cycle");
  chk_rvalid_cause: assert property (o_rvalid |-> $past(i_rd))
    else $error("read valid without a read strobe");
  chk_gate_cmd: assert property (cmd_wr && i_wdata[7:4] == 4'hE && i_wdata[2:0] == MC_GATE
    |=> o_output_gate_bit == $past(i_wdata[3])) else $error("output gate command missed");
  chk_width_cmd: assert property (cmd_wr && i_wdata[7:4] == 4'hE && i_wdata[2:0] == MC_WIDTH
    |=> o_bus_width_bit == $past(i_wdata[3])) else $error("bus width command missed");
  chk_seq_cmd: assert property (cmd_wr && i_wdata[7:4] == 4'hE && i_wdata[2:0] == MC_SEQ
    |=> o_sequencing_disable_bit == $past(i_wdata[3])) else $error("sequencing command missed");
  chk_master_reset: assert property (cmd_wr && i_wdata == CMD_MASTER_RESET |=>
    !o_output_gate_bit && !o_bus_width_bit && !o_sequencing_disable_bit && o_counter_out == '0)
    else $error("master reset left state behind");
  chk_out_set: assert property (cmd_wr && i_wdata[7:3] == 5'h1D && n_ok
    |=> (o_counter_out & $past(n_sel)) == $past(n_sel)) else $error("output bit not set");
  chk_out_clr: assert property (cmd_wr && i_wdata[7:3] == 5'h1C && n_ok
    |=> (o_counter_out & $past(n_sel)) == '0) else $error("output bit not cleared");
  chk_mm_quiet: assert property ($changed({o_output_gate_bit, o_bus_width_bit,
    o_sequencing_disable_bit}) |-> $past(i_wr)) else $error("master bit moved without a write");
endmodule // ctmcp_props
`default_nettype wire

// File: testbench/ctmcp_host.sv
// Host processor model driving the byte-wide I/O ports
`timescale 1ns/1ps
`default_nettype none
module ctmcp_host (
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  input wire logic i_rvalid,
  output logic o_port_sel,
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_wdata
);
  import ctmcp_pkg::*;
  initial begin
    o_port_sel = PORT_CMD;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 8'h00;
  end
  // ---------------------------------------------------------------
  // Byte cycles, lines scrambled once released
  // ---------------------------------------------------------------
  task automatic wr_byte(input logic sel, input logic [7:0] d);
    @(posedge i_clk);
    o_port_sel <= sel;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_wdata <= ~d;
    o_port_sel <= ~sel;
  endtask
  task automatic rd_byte(input logic sel, output logic [7:0] d, output logic ok);
    @(posedge i_clk);
    o_port_sel <= sel;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    o_port_sel <= ~sel;
    @(posedge i_clk);
    ok = i_rvalid;
    d = i_rdata;
  endtask
endmodule // ctmcp_host
`default_nettype wire

// File: testbench/tb_ctmcp_top.sv
// Self-checking bench of the counter command block
`timescale 1ns/1ps
`default_nettype none
module tb_ctmcp_top;
  import ctmcp_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] src = 5'h00;
  logic sel, wr, rd, rvalid, gate, width, seq;
  logic [7:0] wdata, rdata;
  logic [4:0] outs, oexp;
  logic [15:0] lv [5];
  logic [15:0] w, d;
  logic [2:0] mm;
  logic [7:0] codes [6] = '{8'hE8, 8'hEE, 8'hEF, 8'hE0, 8'hE6, 8'hE7};
  int err_count = 0;
  int tests_run = 0;
  always #50 clk = ~clk;
  ctmcp_top #(.NCH(5)) ctmcp_top_inst (.i_clk(clk), .i_rstn(rst_n), .i_port_sel(sel),
    .i_wr(wr), .i_rd(rd), .i_wdata(wdata), .i_count_src(src), .o_rdata(rdata),
    .o_rvalid(rvalid), .o_counter_out(outs), .o_output_gate_bit(gate),
    .o_bus_width_bit(width), .o_sequencing_disable_bit(seq));
  ctmcp_host ctmcp_host_inst (.i_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid),
    .o_port_sel(sel), .o_wr(wr), .o_rd(rd), .o_wdata(wdata));
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] ptr(input logic [1:0] el, input logic [2:0] grp);
    return {3'h0, el, grp};
  endfunction
  function automatic logic [15:0] stat(input logic [4:0] o, input logic bp);
    return {8'h00, 2'h0, o, bp};
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] c);
    ctmcp_host_inst.wr_byte(PORT_CMD, c);
    @(negedge clk);
  endtask
  task automatic wr_word(input logic [15:0] v);
    ctmcp_host_inst.wr_byte(PORT_DATA, v[7:0]);
    ctmcp_host_inst.wr_byte(PORT_DATA, v[15:8]);
  endtask
  task automatic rd_b(input logic s, output logic [7:0] b);
    logic ok;
    ctmcp_host_inst.rd_byte(s, b, ok);
    check(16'(ok), 16'h0001);
  endtask
  task automatic rd_word(output logic [15:0] v);
    rd_b(PORT_DATA, v[7:0]);
    rd_b(PORT_DATA, v[15:8]);
  endtask
  task automatic status_is(input logic [15:0] e);
    logic [7:0] b;
    rd_b(PORT_CMD, b);
    check({8'h00, b}, e);
  endtask
  task automatic word_is(input logic [7:0] p, input logic [15:0] e);
    logic [15:0] v;
    cmd(p);
    rd_word(v);
    check(v, e);
  endtask
  task automatic pulse(input int ch, input int n);
    repeat (n) begin
      @(posedge clk);
      src[ch] <= 1'b1;
      repeat (3) @(posedge clk);
      src[ch] <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask
  task automatic finish_test();
    $display("Comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(45066));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    status_is(stat(5'h00, 1'b1));
    cmd(ptr(EL_MASTER, GRP_CTRL));
    wr_word(16'h0000);
    mm = 3'h0;
    foreach (codes[i]) begin
      cmd(codes[i]);
      mm[(codes[i][2:0] == 3'h0) ? 2 : (codes[i][0] ? 1 : 0)] = codes[i][3];
      check({13'h0000, seq, width, gate}, {13'h0000, mm});
    end
    for (int g = 1; g <= 5; g++) begin
      lv[g-1] = 16'($urandom_range(16'hFFFF, 16'h0100));
      cmd(ptr(EL_MODE, 3'(g)));
      wr_word(16'h0000);
      wr_word(lv[g-1]);
      status_is(stat(5'h00, 1'b1));
    end
    cmd(8'h5F);
    for (int g = 1; g <= 5; g++) cmd(8'hF0 | 8'(g));
    cmd(8'hBF);
    for (int g = 1; g <= 5; g++) word_is(ptr(EL_HOLD, 3'(g)), lv[g-1] - 16'h0001);
    lv[2] = 16'($urandom);
    cmd(ptr(EL_LOADR, 3'h3));
    ctmcp_host_inst.wr_byte(PORT_DATA, ~lv[2][7:0]);
    status_is(stat(5'h00, 1'b0));
    cmd(ptr(EL_LOADR, 3'h3));
    status_is(stat(5'h00, 1'b1));
    wr_word(lv[2]);
    word_is(ptr(EL_LOADR, 3'h3), lv[2]);
    cmd(8'h61);
    pulse(0, 3);
    cmd(8'hA1);
    word_is(ptr(EL_HOLD, 3'h1), lv[0] - 16'h0003);
    pulse(0, 1);
    cmd(8'h81);
    pulse(0, 2);
    word_is(ptr(EL_HOLD, 3'h1), lv[0] - 16'h0004);
    cmd(8'hA1);
    word_is(ptr(EL_HOLD, 3'h1), lv[0] - 16'h0004);
    cmd(8'h21);
    pulse(0, 2);
    cmd(8'hC1);
    pulse(0, 2);
    cmd(8'hA1);
    word_is(ptr(EL_HOLD, 3'h1), lv[0] - 16'h0006);
    cmd(ptr(EL_HOLDINC, 3'h5));
    rd_word(d);
    check(d, lv[4] - 16'h0001);
    rd_word(d);
    check(d, lv[0] - 16'h0006);
    oexp = 5'h00;
    for (int n = 1; n <= 5; n++) begin
      cmd(8'hE8 | 8'(n));
      oexp[n-1] = 1'b1;
      check({11'h000, outs}, {11'h000, oexp});
    end
    cmd(8'hFE);
    status_is(stat(oexp, 1'b1));
    check({13'h0000, seq, width, gate}, 16'h0000);
    for (int n = 5; n >= 1; n--) begin
      cmd(8'hE0 | 8'(n));
      oexp[n-1] = 1'b0;
      check({11'h000, outs}, {11'h000, oexp});
    end
    w = 16'($urandom_range(16'hFFFF, 16'h0000));
    cmd(ptr(EL_ALARM1, GRP_CTRL));
    wr_word(w);
    wr_word(~w);
    wr_word(16'h4000);
    cmd(ptr(EL_ALARM1, GRP_CTRL));
    check({15'h0000, seq}, 16'h0001);
    rd_word(d);
    check(d, w);
    rd_word(d);
    check(d, w);
    cmd(8'hE0);
    cmd(ptr(EL_ALARM1, GRP_CTRL));
    rd_word(d);
    rd_word(d);
    check(d, ~w);
    for (int i = 0; i < 2; i++) begin
      cmd(ptr(EL_LOADR, 3'(6 * i)));
      wr_word(w);
      word_is(ptr(EL_LOADR, 3'(6 * i)), 16'h0000);
    end
    cmd(8'hEF);
    cmd(ptr(EL_LOADR, 3'h2));
    ctmcp_host_inst.wr_byte(PORT_DATA, w[7:0]);
    status_is(stat(5'h00, 1'b1));
    cmd(ptr(EL_LOADR, 3'h2));
    rd_b(PORT_DATA, d[7:0]);
    check({8'h00, d[7:0]}, {8'h00, w[7:0]});
    cmd(8'hE7);
    word_is(ptr(EL_LOADR, 3'h2), {8'h00, w[7:0]});
    cmd(8'hE9);
    cmd(8'hEE);
    cmd(CMD_MASTER_RESET);
    check({8'h00, outs, gate, width, seq}, 16'h0000);
    status_is(stat(5'h00, 1'b1));
    word_is(ptr(EL_LOADR, 3'h1), 16'h0000);
    finish_test();
  end
  initial begin
    #1_000_000;
    err_count++;
    finish_test();
  end
endmodule // tb_ctmcp_top
bind ctmcp_top ctmcp_props #(.NCH(NCH)) ctmcp_props_inst (.i_clk(i_clk), .i_rstn(i_rstn),
  .i_port_sel(i_port_sel), .i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata), .o_rvalid(o_rvalid),
  .o_counter_out(o_counter_out), .o_output_gate_bit(o_output_gate_bit),
  .o_bus_width_bit(o_bus_width_bit), .o_sequencing_disable_bit(o_sequencing_disable_bit));
`default_nettype wire
